// >>> src/sss_stack_slice.sv
// sequence stack slice: entries 23 to 26 and their sequencer step
// assumes frames arrive synchronous to ref_clk, one per strobe
//
// Contract
// - frame bit 15: zero reads, one writes
// - bits 14..9 must hold the entry's address
// - return flag clear: step to following entry
// - return flag set: jump back to first entry
// - bits 7..4 pick converter B channel
// - bits 3..0 pick converter A channel
// - entries 24..26 at 0x38..0x3A, preset addresses
// - entry 23 at 0x37 reads 0x6E00 after reset
`timescale 1ns/100ps
`default_nettype none

module sss_stack_slice (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register frame port
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  // read answer
  output logic rd_valid,
  output logic [15:0] rd_data,
  // sequencer control
  input wire logic seq_enter,
  input wire logic conv_done,
  // sequencer status and channel selection
  output logic seq_active,
  output logic [1:0] active_slot,
  output logic [3:0] conv_a_channel,
  output logic [3:0] conv_b_channel,
  output logic seq_return_first,
  output logic seq_next_slice
);

  // ==========================================================
  // frame decode
  sss_pkg::sss_entry_type frame; // incoming frame as fields
  sss_pkg::sss_entry_type entries [sss_pkg::SSS_ENTRIES]; // stored entries
  logic [5:0] addr_off; // frame address minus slice base
  logic in_slice; // frame address falls on this slice
  logic [1:0] hit_slot; // slot the frame addresses
  logic wr_frame; // valid write frame on this slice
  logic rd_frame; // valid read frame on this slice

  assign frame = frame_data;
  // the address field alone selects the entry
  assign addr_off = frame.self_address_field - sss_pkg::SSS_OFS_BASE;
  assign in_slice = frame_valid && (addr_off < 6'h04);
  assign hit_slot = addr_off[1:0];
  // direction bit picks write or read
  assign wr_frame = in_slice && frame.dir;
  assign rd_frame = in_slice && !frame.dir;

  // ==========================================================
  // entry registers, preset with their own address
  genvar gi;
  generate
    for (gi = 0; gi < sss_pkg::SSS_ENTRIES; gi++) begin : g_entry
      sss_entry_reg #(
        .SELF_ADDR(6'(sss_pkg::SSS_OFS_BASE + 6'(gi)))
      ) u_entry (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(wr_frame && (hit_slot == 2'(gi))),
        .wr_low(frame_data[8:0]),
        .entry_q(entries[gi])
      );
    end
  endgenerate

  // ==========================================================
  // read answer
  logic rd_valid_q; // answer strobe, one cycle after a read frame
  logic [15:0] rd_data_q; // answered entry

  // a read frame returns the addressed entry next cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= rd_frame;
      rd_data_q <= rd_frame ? entries[hit_slot] : rd_data_q;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;

  // ==========================================================
  // sequencer walk
  sss_pkg::sss_state_type state_q, state_d; // walking or idle
  logic [1:0] slot_q, slot_d; // active entry slot
  logic ret_q, ret_d; // jump-back pulse
  logic pass_q, pass_d; // hand-on pulse to following slice
  logic step; // conversion finished on an active entry
  logic cur_ret; // return flag of the active entry

  assign step = (state_q == sss_pkg::SSS_RUN) && conv_done;
  assign cur_ret = entries[slot_q].stack_return_flag;

  // next walk state from enter and conversion completion
  always_comb begin
    state_d = state_q;
    slot_d = slot_q;
    ret_d = 1'b0;
    pass_d = 1'b0;
    case (state_q)
      sss_pkg::SSS_IDLE: begin
        // wait to be handed the walk
        if (seq_enter) begin
          state_d = sss_pkg::SSS_RUN;
          slot_d = 2'h0;
        end
      end
      sss_pkg::SSS_RUN: begin
        if (seq_enter) begin
          // restart at the slice's first entry
          slot_d = 2'h0;
        end else if (step && cur_ret) begin
          // loop closes at the first stack entry
          state_d = sss_pkg::SSS_IDLE;
          slot_d = 2'h0;
          ret_d = 1'b1;
        end else if (step && (slot_q == sss_pkg::SSS_LAST_SLOT)) begin
          // following entry lives past this slice
          state_d = sss_pkg::SSS_IDLE;
          slot_d = 2'h0;
          pass_d = 1'b1;
        end else if (step) begin
          // move to the following entry
          slot_d = slot_q + 2'h1;
        end
      end
      default: begin
        state_d = sss_pkg::SSS_IDLE;
        slot_d = 2'h0;
      end
    endcase
  end

  // walk state registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= sss_pkg::SSS_IDLE;
      slot_q <= 2'h0;
      ret_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      ret_q <= ret_d;
      pass_q <= pass_d;
    end
  end

  // ==========================================================
  // channel selection outputs
  logic [3:0] cha_q, chb_q; // codes of the entry being executed

  // codes pass raw; their meaning follows the main select encoding
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cha_q <= 4'h0;
      chb_q <= 4'h0;
    end else begin
      cha_q <= entries[slot_d].converter_a_channel_code;
      chb_q <= entries[slot_d].converter_b_channel_code;
    end
  end

  assign seq_active = (state_q == sss_pkg::SSS_RUN);
  assign active_slot = slot_q;
  assign conv_a_channel = cha_q;
  assign conv_b_channel = chb_q;
  assign seq_return_first = ret_q;
  assign seq_next_slice = pass_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_e23_a: assert property ($past(rst) |->
    entries[0] == sss_pkg::SSS_RST_ENTRY_23)
    else $error("entry 23 reset value wrong");
  reset_e24_26_a: assert property ($past(rst) |->
    entries[1] == sss_pkg::SSS_RST_ENTRY_24 &&
    entries[2] == sss_pkg::SSS_RST_ENTRY_25 &&
    entries[3] == sss_pkg::SSS_RST_ENTRY_26)
    else $error("entries 24 to 26 reset value wrong");
  read_e23_a: assert property (
    frame_valid && frame_data[15:9] == 7'h37 |=>
    rd_valid && rd_data == $past(entries[0]))
    else $error("entry 23 read answer wrong");
  write_e24_a: assert property (
    frame_valid && frame_data[15:9] == 7'h78 |=>
    entries[1][8:0] == $past(frame_data[8:0]) && !rd_valid)
    else $error("entry 24 write not stored");
  addr_select_a: assert property (
    frame_valid && frame_data[14:9] != sss_pkg::SSS_OFS_ENTRY_25 |=>
    $stable(entries[2]))
    else $error("entry 25 changed by foreign frame");
  step_next_a: assert property (
    step && !cur_ret && !seq_enter && slot_q != 2'h3 |=>
    seq_active && active_slot == $past(slot_q) + 2'h1)
    else $error("no step to following entry");
  step_pass_a: assert property (
    step && !cur_ret && !seq_enter && slot_q == 2'h3 |=>
    seq_next_slice && !seq_active ##1 !seq_next_slice)
    else $error("no hand-on after last entry");
  return_first_a: assert property (
    step && cur_ret && !seq_enter |=>
    seq_return_first && active_slot == 2'h0 && !seq_active)
    else $error("return flag did not jump back");
  chan_a_a: assert property (
    seq_active && $stable(entries[slot_q]) && $stable(slot_q) |->
    conv_a_channel == entries[slot_q].converter_a_channel_code)
    else $error("converter A code mismatch");
  chan_b_a: assert property (
    seq_active && $stable(entries[slot_q]) && $stable(slot_q) |->
    conv_b_channel == entries[slot_q].converter_b_channel_code)
    else $error("converter B code mismatch");

  walk_pass_c: cover property (seq_enter ##[1:40] seq_next_slice);
  walk_return_c: cover property (step ##1 seq_return_first);
  read_write_c: cover property (wr_frame ##[1:4] rd_frame ##1 rd_valid);

endmodule
`default_nettype wire

// >>> src/sss_pkg.sv
// package for the sequence stack slice: offsets, field layout, resets
// assumes one register frame port and one device clock and reset
package sss_pkg;

  // ==========================================================
  // register offsets
  localparam logic [5:0] SSS_OFS_ENTRY_23 = 6'h37;
  localparam logic [5:0] SSS_OFS_ENTRY_24 = 6'h38;
  localparam logic [5:0] SSS_OFS_ENTRY_25 = 6'h39;
  localparam logic [5:0] SSS_OFS_ENTRY_26 = 6'h3A;
  // first offset of the slice; entry slots count up from here
  localparam logic [5:0] SSS_OFS_BASE = SSS_OFS_ENTRY_23;

  // ==========================================================
  // slice geometry
  localparam int SSS_ENTRIES = 4;
  localparam logic [1:0] SSS_LAST_SLOT = 2'h3;

  // ==========================================================
  // field positions within a 16-bit frame
  localparam int SSS_DIR_POS = 15;
  localparam int SSS_ADDR_LSB = 9;
  localparam int SSS_RET_POS = 8;
  localparam int SSS_CHB_LSB = 4;
  localparam int SSS_CHA_LSB = 0;

  // ==========================================================
  // reset values of the whole entries
  localparam logic [15:0] SSS_RST_ENTRY_23 = 16'h6E00;
  localparam logic [15:0] SSS_RST_ENTRY_24 = 16'h7000;
  localparam logic [15:0] SSS_RST_ENTRY_25 = 16'h7200;
  localparam logic [15:0] SSS_RST_ENTRY_26 = 16'h7400;
  // reset value of the writable low fields
  localparam logic [8:0] SSS_RST_LOW = 9'h000;

  // ==========================================================
  // one stack entry, laid out as its frame
  typedef struct packed {
    logic dir;
    logic [5:0] self_address_field;
    logic stack_return_flag;
    logic [3:0] converter_b_channel_code;
    logic [3:0] converter_a_channel_code;
  } sss_entry_type;

  // sequencer walk state
  typedef enum logic {
    SSS_IDLE = 1'b0,
    SSS_RUN = 1'b1
  } sss_state_type;

endpackage

// >>> src/sss_entry_reg.sv
// one sequence stack entry register
// assumes the caller decodes the frame and gives a one-cycle write strobe
`timescale 1ns/100ps
`default_nettype none

module sss_entry_reg #(
  parameter logic [5:0] SELF_ADDR = 6'h37
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [8:0] wr_low,
  // stored entry
  output var sss_pkg::sss_entry_type entry_q
);

  // ==========================================================
  // storage
  logic [8:0] low_q; // return flag and both channel codes

  // low fields load on a matching write frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_q <= sss_pkg::SSS_RST_LOW;
    end else if (wr_en) begin
      low_q <= wr_low;
    end
  end

  // read view: direction reads as read, address is the entry's own
  assign entry_q = {1'b0, SELF_ADDR, low_q};

endmodule
`default_nettype wire

// >>> bench/sss_host_model.sv
// host model: drives register frames into the stack slice
// assumes the caller enters its task just after a rising edge
`timescale 1ns/100ps
`default_nettype none

module sss_host_model (
  // clock
  input wire logic ref_clk,
  // frame port
  output var logic frame_valid,
  output var logic [15:0] frame_data
);
  // ==========================================================
  // frame driver
  // quiet port at time zero
  initial begin
    frame_valid = 1'b0;
    frame_data = 16'h0000;
  end

  // one frame cycle; idle cycles scramble the lines so stale data never
  // looks like a frame
  task automatic frm(input logic v, input logic [15:0] d);
    frame_valid = v;
    frame_data = v ? d : ~frame_data;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

`default_nettype wire

// >>> bench/sss_stack_slice_tb.sv
// testbench for the sequence stack slice: frames, read answers, walks
// assumes the host model drives frames and the bench drives the walk
`timescale 1ns/100ps
`default_nettype none

module sss_stack_slice_tb;
  // ==========================================================
  // signals
  logic ref_clk, rst, frame_valid, rd_valid, seq_enter, conv_done;
  logic seq_active, seq_return_first, seq_next_slice;
  logic [15:0] frame_data, rd_data;
  logic [1:0] active_slot;
  logic [3:0] conv_a_channel, conv_b_channel;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] exp_q[$]; // expected read answers, oldest first
  logic [8:0] lo[4] = '{default: 9'h000}; // model of writable fields
  logic [31:0] seed = 32'h13529D1B;

  // ==========================================================
  // instances
  sss_host_model host (.ref_clk(ref_clk), .frame_valid(frame_valid),
    .frame_data(frame_data));
  sss_stack_slice u_sss_stack_slice (.ref_clk(ref_clk), .rst(rst),
    .frame_valid(frame_valid), .frame_data(frame_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .seq_enter(seq_enter),
    .conv_done(conv_done), .seq_active(seq_active),
    .active_slot(active_slot), .conv_a_channel(conv_a_channel),
    .conv_b_channel(conv_b_channel), .seq_return_first(seq_return_first),
    .seq_next_slice(seq_next_slice));

  // ==========================================================
  // clock, timeout, answer watcher
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end

  // every answer takes the oldest note; an answer with none is a fault
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rd_data, 16'hFFFF);
      else chk(rd_data, exp_q.pop_front());
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // frame to entry i: write stores l, read notes the expected answer
  task automatic acc(input logic w, input int i, input logic [8:0] l);
    logic [5:0] a;
    a = sss_pkg::SSS_OFS_BASE + 6'(i);
    if (w) lo[i] = l;
    else exp_q.push_back({1'b0, a, lo[i]});
    host.frm(1'b1, {w, a, l});
  endtask

  // one walk cycle, then compare status; channels only while walking
  task automatic sq(input logic e, input logic d, input logic act,
    input logic [1:0] s, input logic r, input logic n);
    logic [15:0] g, x;
    seq_enter = e;
    conv_done = d;
    @(posedge ref_clk);
    #1;
    g = {3'h0, seq_active, seq_return_first, seq_next_slice, 10'h000};
    x = {3'h0, act, r, n, 10'h000};
    if (act) begin
      g[9:0] = {active_slot, conv_b_channel, conv_a_channel};
      x[9:0] = {s, lo[s][7:0]};
    end
    chk(g, x);
  endtask

  // summary and verdict
  task automatic print_verdict();
    if (exp_q.size() != 0) fails++;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    seq_enter = 1'b0;
    conv_done = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // reset contents, back to back reads
    for (int i = 0; i < 4; i++) acc(1'b0, i, 9'h000);
    // random writes, each read back at once
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      acc(1'b1, i, seed[8:0]);
      acc(1'b0, i, 9'h000);
    end
    // foreign addresses are ignored; a read with data never writes
    host.frm(1'b1, {1'b1, 6'h3B, 9'h1FF});
    host.frm(1'b1, {1'b0, 6'h36, 9'h000});
    acc(1'b0, 3, 9'h000);
    acc(1'b0, 0, ~lo[0]);
    acc(1'b0, 0, 9'h000);
    // program a walk: return flag only on entry 25
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      acc(1'b1, i, {i == 2, seed[7:0]});
    end
    host.frm(1'b0, 16'h0000);
    sq(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
    sq(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0);
    sq(1'b0, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0);
    sq(1'b0, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0);
    sq(1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0);
    // clear the flag and walk past the last entry
    acc(1'b1, 2, {1'b0, lo[2][7:0]});
    // drop the strobe so the write is not repeated during the walk
    host.frm(1'b0, 16'h0000);
    sq(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0);
    sq(1'b0, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0);
    sq(1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0);
    for (int s = 1; s < 4; s++) begin
      sq(1'b0, 1'b1, 1'b1, 2'(s), 1'b0, 1'b0);
    end
    sq(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1);
    sq(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    host.frm(1'b0, 16'h0000);
    host.frm(1'b0, 16'h0000);
    print_verdict();
  end
endmodule

`default_nettype wire
